// ---- design/pmv_config_bank.sv ----
// Behaviour
// - Capability byte reads D0h, read-only, bit 7 reports packet error checking.
// - Capability bits 6 to 5 read 10: bus clock up to 1 MHz.
// - Capability bit 4 reads 1: alert output and alert response supported.
// - Capability bits 3, 2 and 1 to 0 all read zero.
// - Format byte reads 17h, mode bits 7 to 5 zero select LINEAR16.
// - Format bits 4 to 0 are 10111, exponent -9 for the output voltage words.
// - Offset powers up with per-device factory trim, host-adjustable in 1.953 mV steps.
// - Divider ratio defaults to E808h and accepts only 0.125, 0.25, 0.5, 1.
// - Source select 00 makes the setpoint, not a margin, the output target.
`timescale 1ns/10ps
`default_nettype none

module pmv_config_bank (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Decoded bus command, one per valid cycle
    input wire logic cmd_valid,
    input wire pmv_pkg::pmv_cmd_type cmd,
    // Response, one cycle after the command
    output logic rsp_valid,
    output pmv_pkg::pmv_rsp_type rsp,
    // Device inputs
    input wire logic [1:0] op_source_sel,
    input wire logic [15:0] trim_factory,
    // Configuration outputs
    output logic [15:0] vout_target,
    output logic [15:0] alert_source_mask,
    output logic [15:0] voltage_ramp_slope,
    output logic [15:0] feedback_divider_ratio,
    output logic [15:0] switching_rate_setting,
    output logic [15:0] input_turn_on_threshold,
    output logic [15:0] input_turn_off_threshold
);

    localparam int N = pmv_pkg::RW_COUNT;

    logic [N-1:0] hit;
    logic [N-1:0] load;
    logic [N-1:0][15:0] din;
    logic [N-1:0][15:0] q;
    logic hit_cap;
    logic hit_fmt;
    logic ratio_ok;
    logic write_req;
    logic write_ok;
    logic [15:0] rdata;
    logic factory_pending_r;
    logic factory_pending_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    pmv_pkg::pmv_rsp_type rsp_r;
    pmv_pkg::pmv_rsp_type rsp_nxt;

    // Command decode.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            hit[i] = (cmd.code == pmv_pkg::RW_CODE[i]);
        end
        hit_cap = (cmd.code == pmv_pkg::CODE_CAPABILITY);
        hit_fmt = (cmd.code == pmv_pkg::CODE_VOUT_FORMAT);
    end

    // Only the four documented ratio codes are taken.
    always_comb begin
        ratio_ok = (cmd.wdata == pmv_pkg::DIV_RATIO_1) ||
                   (cmd.wdata == pmv_pkg::DIV_RATIO_HALF) ||
                   (cmd.wdata == pmv_pkg::DIV_RATIO_QUARTER) ||
                   (cmd.wdata == pmv_pkg::DIV_RATIO_EIGHTH);
    end

    assign write_req = cmd_valid && cmd.write;
    // Read-only and unknown codes never reach a load enable.
    assign write_ok = write_req && (|hit) &&
                      !(hit[pmv_pkg::IDX_DIVIDER] && !ratio_ok);

    // The factory trim is taken in the first cycle after reset release, since an
    // asynchronous reset may only load constants.
    always_comb begin
        factory_pending_nxt = 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            factory_pending_r <= 1'b1;
        end else begin
            factory_pending_r <= factory_pending_nxt;
        end
    end

    // A host write in the same cycle wins over the factory load.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            load[i] = write_ok && hit[i];
            din[i] = cmd.wdata;
        end
        if (factory_pending_r && !load[pmv_pkg::IDX_OFFSET]) begin
            load[pmv_pkg::IDX_OFFSET] = 1'b1;
            din[pmv_pkg::IDX_OFFSET] = trim_factory;
        end
    end

    generate
        for (genvar g = 0; g < N; g++) begin : g_cell
            pmv_reg_cell #(
                .WIDTH(16),
                .RESET_VALUE(pmv_pkg::RW_RESET[g])
            ) u_cell (
                .clk_sys(clk_sys),
                .rst(rst),
                .load(load[g]),
                .din(din[g]),
                .q(q[g])
            );
        end
    endgenerate

    // Read data: constant bytes for the read-only codes.
    always_comb begin
        rdata = 16'h0000;
        if (hit_cap) begin
            rdata = {8'h00, pmv_pkg::CAPABILITY_VALUE};
        end else if (hit_fmt) begin
            rdata = {8'h00, pmv_pkg::VOUT_FORMAT_VALUE};
        end else begin
            for (int i = 0; i < N; i++) begin
                if (hit[i]) begin
                    rdata = q[i];
                end
            end
        end
    end

    always_comb begin
        rsp_valid_nxt = cmd_valid;
        rsp_nxt = rsp_r;
        if (cmd_valid) begin
            rsp_nxt.data = cmd.write ? 16'h0000 : rdata;
            rsp_nxt.is_byte = hit_cap || hit_fmt;
            rsp_nxt.refused = cmd.write ? !write_ok : !(hit_cap || hit_fmt || (|hit));
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;

    pmv_vout_target u_target (
        .clk_sys(clk_sys),
        .rst(rst),
        .src_sel(op_source_sel),
        .setpoint(q[pmv_pkg::IDX_SETPOINT]),
        .margin_high(q[pmv_pkg::IDX_MARGIN_HIGH]),
        .margin_low(q[pmv_pkg::IDX_MARGIN_LOW]),
        .offset(q[pmv_pkg::IDX_OFFSET]),
        .ceiling(q[pmv_pkg::IDX_CEILING]),
        .target(vout_target)
    );

    assign alert_source_mask = q[pmv_pkg::IDX_ALERT_MASK];
    assign voltage_ramp_slope = q[pmv_pkg::IDX_RAMP_SLOPE];
    assign feedback_divider_ratio = q[pmv_pkg::IDX_DIVIDER];
    assign switching_rate_setting = q[pmv_pkg::IDX_SWITCH_RATE];
    assign input_turn_on_threshold = q[pmv_pkg::IDX_INPUT_TURN_ON_THRESHOLD];
    assign input_turn_off_threshold = q[pmv_pkg::IDX_INPUT_TURN_OFF_THRESHOLD];

    // Checks.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_read(logic [7:0] c);
        cmd_valid && !cmd.write && cmd.code == c;
    endsequence

    sequence s_write(logic [7:0] c);
        cmd_valid && cmd.write && cmd.code == c;
    endsequence

    a_cap_read_value: assert property (
        s_read(8'h19) |=> rsp_valid && rsp.data == 16'h00d0 && rsp.is_byte && !rsp.refused)
        else $error("capability read wrong");

    a_cap_bit_fields: assert property (
        s_read(8'h19) |=> rsp.data[6:5] == 2'h2 && rsp.data[4] && rsp.data[7])
        else $error("capability fields wrong");

    a_format_read_value: assert property (
        s_read(8'h20) |=> rsp_valid && rsp.data == 16'h0017 && !rsp.refused)
        else $error("format read wrong");

    a_ro_write_refused: assert property (
        (s_write(8'h19) or s_write(8'h20)) |=> rsp_valid && rsp.refused)
        else $error("read-only write accepted");

    a_ratio_reject: assert property (
        s_write(8'h29) ##0 !(cmd.wdata inside {16'he808, 16'he804, 16'he802, 16'he801})
        |=> rsp.refused && $stable(feedback_divider_ratio))
        else $error("bad divider ratio taken");

    a_ratio_accept: assert property (
        s_write(8'h29) ##0 (cmd.wdata inside {16'he808, 16'he804, 16'he802, 16'he801})
        |=> !rsp.refused && feedback_divider_ratio == $past(cmd.wdata))
        else $error("valid divider ratio lost");

    a_factory_trim_load: assert property (
        $fell(factory_pending_r) && !$past(write_ok && hit[pmv_pkg::IDX_OFFSET])
        |-> q[pmv_pkg::IDX_OFFSET] == $past(trim_factory))
        else $error("factory trim not loaded");

    sequence s_quiet_setpoint;
        (op_source_sel == 2'h0 && !write_req) [*3];
    endsequence

    a_setpoint_source: assert property (
        s_quiet_setpoint ##0 (!factory_pending_r &&
            $signed({2'h0, q[pmv_pkg::IDX_SETPOINT]}) +
            $signed({{2{q[pmv_pkg::IDX_OFFSET][15]}}, q[pmv_pkg::IDX_OFFSET]}) >= 0 &&
            $signed({2'h0, q[pmv_pkg::IDX_SETPOINT]}) +
            $signed({{2{q[pmv_pkg::IDX_OFFSET][15]}}, q[pmv_pkg::IDX_OFFSET]}) <=
            $signed({2'h0, q[pmv_pkg::IDX_CEILING]}))
        |-> vout_target == q[pmv_pkg::IDX_SETPOINT] + q[pmv_pkg::IDX_OFFSET])
        else $error("target not from setpoint");

    a_response_latency: assert property (
        cmd_valid |=> rsp_valid)
        else $error("response missing");

    a_idle_no_response: assert property (
        !cmd_valid |=> !rsp_valid)
        else $error("response without command");

    a_write_data_zero: assert property (
        cmd_valid && cmd.write |=> rsp_valid && rsp.data == 16'h0000)
        else $error("write response carries data");

    a_write_accepted: assert property (
        write_ok |=> rsp_valid && !rsp.refused)
        else $error("accepted write reported refused");

    a_unknown_refused: assert property (
        cmd_valid && !hit_cap && !hit_fmt && !(|hit) |=> rsp.refused && rsp.data == 16'h0000 && !rsp.is_byte)
        else $error("unknown code not refused");

    a_word_flag: assert property (
        cmd_valid && !hit_cap && !hit_fmt |=> !rsp.is_byte)
        else $error("word response marked as byte");

    // A refused write to a read-only code must leave every stored word alone.
    a_ro_write_no_change: assert property (
        (s_write(8'h19) or s_write(8'h20)) |=> $stable(q))
        else $error("read-only write changed a register");

    a_format_fields: assert property (
        s_read(8'h20) |=> rsp.data[7:5] == 3'h0 && rsp.data[4:0] == 5'h17 && rsp.is_byte)
        else $error("format fields wrong");

    a_offset_write: assert property (
        s_write(8'h22) |=> q[pmv_pkg::IDX_OFFSET] == $past(cmd.wdata))
        else $error("offset write lost");

    a_setpoint_write: assert property (
        s_write(8'h21) |=> q[pmv_pkg::IDX_SETPOINT] == $past(cmd.wdata))
        else $error("setpoint write lost");

    a_ratio_legal: assert property (
        feedback_divider_ratio inside {16'he808, 16'he804, 16'he802, 16'he801})
        else $error("divider holds an illegal ratio");

    // The target is built from the previous cycle's words, so the ceiling must have held still.
    a_target_ceiling: assert property (
        $stable(q[pmv_pkg::IDX_CEILING]) |-> vout_target <= q[pmv_pkg::IDX_CEILING])
        else $error("target above ceiling");

    // Two quiet cycles on one select leave the target equal to that word when no offset applies.
    sequence s_quiet_sel(logic [1:0] s);
        (op_source_sel == s && !write_req && !factory_pending_r) [*2];
    endsequence

    a_margin_low_source: assert property (
        s_quiet_sel(2'h1) ##0 (q[pmv_pkg::IDX_OFFSET] == 16'h0000 &&
            q[pmv_pkg::IDX_MARGIN_LOW] <= q[pmv_pkg::IDX_CEILING])
        |-> vout_target == q[pmv_pkg::IDX_MARGIN_LOW])
        else $error("target not from lower margin");

    a_margin_high_source: assert property (
        s_quiet_sel(2'h2) ##0 (q[pmv_pkg::IDX_OFFSET] == 16'h0000 &&
            q[pmv_pkg::IDX_MARGIN_HIGH] <= q[pmv_pkg::IDX_CEILING])
        |-> vout_target == q[pmv_pkg::IDX_MARGIN_HIGH])
        else $error("target not from upper margin");

endmodule

`default_nettype wire

// ---- design/pmv_reg_cell.sv ----
`timescale 1ns/10ps
`default_nettype none

module pmv_reg_cell #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Load port
    input wire logic load,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] value_r;
    logic [WIDTH-1:0] value_nxt;

    always_comb begin
        value_nxt = load ? din : value_r;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            value_r <= RESET_VALUE;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign q = value_r;

endmodule

`default_nettype wire

// ---- design/pmv_vout_target.sv ----
`timescale 1ns/10ps
`default_nettype none

module pmv_vout_target (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Source registers
    input wire logic [1:0] src_sel,
    input wire logic [15:0] setpoint,
    input wire logic [15:0] margin_high,
    input wire logic [15:0] margin_low,
    input wire logic [15:0] offset,
    input wire logic [15:0] ceiling,
    // Target in steps of 2^-9 V
    output logic [15:0] target
);

    logic [15:0] target_r;
    logic [15:0] target_nxt;
    logic [15:0] base;
    logic signed [17:0] sum;

    // Setpoints are unsigned mantissas; the offset alone is signed.
    always_comb begin
        unique case (src_sel)
            pmv_pkg::SRC_MARGIN_LOW: base = margin_low;
            pmv_pkg::SRC_MARGIN_HIGH: base = margin_high;
            default: base = setpoint;
        endcase
        sum = $signed({2'h0, base}) + $signed({{2{offset[15]}}, offset});
        if (sum < 0) begin
            target_nxt = 16'h0000;
        end else if (sum > $signed({2'h0, ceiling})) begin
            target_nxt = ceiling;
        end else begin
            target_nxt = sum[15:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            target_r <= 16'h0000;
        end else begin
            target_r <= target_nxt;
        end
    end

    assign target = target_r;

endmodule

`default_nettype wire

// ---- pkg/pmv_pkg.sv ----
`default_nettype none

package pmv_pkg;

    // Command codes of this bank.
    localparam logic [7:0] CODE_CAPABILITY = 8'h19;
    localparam logic [7:0] CODE_ALERT_MASK = 8'h1b;
    localparam logic [7:0] CODE_VOUT_FORMAT = 8'h20;
    localparam logic [7:0] CODE_SETPOINT = 8'h21;
    localparam logic [7:0] CODE_OFFSET = 8'h22;
    localparam logic [7:0] CODE_CEILING = 8'h24;
    localparam logic [7:0] CODE_MARGIN_HIGH = 8'h25;
    localparam logic [7:0] CODE_MARGIN_LOW = 8'h26;
    localparam logic [7:0] CODE_RAMP_SLOPE = 8'h27;
    localparam logic [7:0] CODE_DIVIDER = 8'h29;
    localparam logic [7:0] CODE_SWITCH_RATE = 8'h33;
    localparam logic [7:0] CODE_INPUT_TURN_ON_THRESHOLD = 8'h35;
    localparam logic [7:0] CODE_INPUT_TURN_OFF_THRESHOLD = 8'h36;

    // Capability byte fields.
    localparam logic CAP_PEC = 1'h1;
    localparam logic [1:0] CAP_BUS_SPEED = 2'h2;
    localparam logic CAP_ALERT = 1'h1;
    localparam logic CAP_NUM_FORMAT = 1'h0;
    localparam logic CAP_AVS = 1'h0;
    localparam logic [1:0] CAP_RESERVED = 2'h0;
    localparam logic [7:0] CAPABILITY_VALUE =
        {CAP_PEC, CAP_BUS_SPEED, CAP_ALERT, CAP_NUM_FORMAT, CAP_AVS, CAP_RESERVED};

    // Output voltage format byte fields.
    localparam logic [2:0] FMT_MODE_LINEAR16 = 3'h0;
    localparam logic [4:0] FMT_EXPONENT = 5'h17;
    localparam logic [7:0] VOUT_FORMAT_VALUE = {FMT_MODE_LINEAR16, FMT_EXPONENT};

    // Writable registers, held as an indexed bank.
    localparam int RW_COUNT = 11;
    localparam int IDX_ALERT_MASK = 0;
    localparam int IDX_SETPOINT = 1;
    localparam int IDX_OFFSET = 2;
    localparam int IDX_CEILING = 3;
    localparam int IDX_MARGIN_HIGH = 4;
    localparam int IDX_MARGIN_LOW = 5;
    localparam int IDX_RAMP_SLOPE = 6;
    localparam int IDX_DIVIDER = 7;
    localparam int IDX_SWITCH_RATE = 8;
    localparam int IDX_INPUT_TURN_ON_THRESHOLD = 9;
    localparam int IDX_INPUT_TURN_OFF_THRESHOLD = 10;

    localparam logic [RW_COUNT-1:0][7:0] RW_CODE = {
        CODE_INPUT_TURN_OFF_THRESHOLD, CODE_INPUT_TURN_ON_THRESHOLD, CODE_SWITCH_RATE, CODE_DIVIDER,
        CODE_RAMP_SLOPE, CODE_MARGIN_LOW, CODE_MARGIN_HIGH, CODE_CEILING,
        CODE_OFFSET, CODE_SETPOINT, CODE_ALERT_MASK};

    // The offset resets to zero and is then loaded from the factory trim input.
    localparam logic [RW_COUNT-1:0][15:0] RW_RESET = {
        16'hf812, 16'hf814, 16'h0258, 16'he808,
        16'he002, 16'h0123, 16'h0142, 16'h1c00,
        16'h0000, 16'h0133, 16'h0000};

    // Accepted feedback divider ratios, exponent -3.
    localparam logic [15:0] DIV_RATIO_1 = 16'he808;
    localparam logic [15:0] DIV_RATIO_HALF = 16'he804;
    localparam logic [15:0] DIV_RATIO_QUARTER = 16'he802;
    localparam logic [15:0] DIV_RATIO_EIGHTH = 16'he801;

    // Operation-command source select, bits 5 to 4.
    localparam logic [1:0] SRC_SETPOINT = 2'h0;
    localparam logic [1:0] SRC_MARGIN_LOW = 2'h1;
    localparam logic [1:0] SRC_MARGIN_HIGH = 2'h2;

    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } pmv_cmd_type;

    typedef struct packed {
        logic [15:0] data;
        logic is_byte;
        logic refused;
    } pmv_rsp_type;

endpackage

`default_nettype wire

// ---- tb/pmbus_vout_config_commands_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module pmbus_vout_config_commands_tb;
    localparam logic [15:0] TRIM = 16'h0040;
    localparam logic [17:0] REF = 18'h00001;
    logic clk_sys;
    logic rst;
    logic cmd_valid;
    pmv_pkg::pmv_cmd_type cmd;
    logic rsp_valid;
    pmv_pkg::pmv_rsp_type rsp;
    logic [1:0] op_source_sel;
    logic [15:0] trim_in;
    logic [15:0] tgt, mask_q, ramp_q, div_q, sw_q, von_q, voff_q;
    int n_errors;
    int check_count;

    pmv_config_bank u_dut (
        .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .op_source_sel(op_source_sel), .trim_factory(trim_in),
        .vout_target(tgt), .alert_source_mask(mask_q), .voltage_ramp_slope(ramp_q),
        .feedback_divider_ratio(div_q), .switching_rate_setting(sw_q),
        .input_turn_on_threshold(von_q), .input_turn_off_threshold(voff_q)
    );

    pmv_host_model u_host (
        .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp)
    );

    task automatic chk(input string what, input logic [111:0] seen, input logic [111:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic acc(input logic wr, input logic [7:0] cd, input logic [15:0] wd,
                       input logic [17:0] exp, input string what);
        logic got;
        pmv_pkg::pmv_rsp_type r;
        u_host.xfer(wr, cd, wd, got, r);
        chk("response strobe", 112'(got), 112'h1);
        chk(what, 112'(r), 112'(exp));
    endtask

    task automatic test_defaults();
        logic [7:0] cd [13] = '{8'h19, 8'h20, 8'h1b, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h27,
                                8'h29, 8'h33, 8'h35, 8'h36};
        logic [15:0] ev [13] = '{16'h00d0, 16'h0017, 16'h0000, 16'h0133, TRIM, 16'h1c00, 16'h0142,
                                 16'h0123, 16'he002, 16'he808, 16'h0258, 16'hf814, 16'hf812};
        for (int i = 0; i < 13; i++) begin
            acc(1'h0, cd[i], 16'h0000, {ev[i], i < 2, 1'h0}, "reset read");
        end
        chk("outputs", {tgt, mask_q, ramp_q, div_q, sw_q, von_q, voff_q},
            {16'h0173, 16'h0000, 16'he002, 16'he808, 16'h0258, 16'hf814, 16'hf812});
        $display("test defaults done");
    endtask

    task automatic test_read_only();
        acc(1'h1, 8'h19, 16'hffff, 18'h00003, "capability write");
        acc(1'h1, 8'h20, 16'h0000, 18'h00003, "format write");
        acc(1'h0, 8'h19, 16'h0000, {16'h00d0, 2'h2}, "capability kept");
        acc(1'h0, 8'h20, 16'h0000, {16'h0017, 2'h2}, "format kept");
        acc(1'h0, 8'h23, 16'h0000, REF, "unmapped read");
        acc(1'h1, 8'h23, 16'h1234, REF, "unmapped write");
        $display("test read only done");
    endtask

    task automatic test_divider();
        logic [15:0] ok [4] = '{16'he801, 16'he802, 16'he804, 16'he808};
        for (int i = 0; i < 4; i++) begin
            acc(1'h1, 8'h29, ok[i], 18'h0, "divider write");
            acc(1'h0, 8'h29, 16'h0000, {ok[i], 2'h0}, "divider read");
            chk("divider port", 112'(div_q), 112'(ok[i]));
        end
        acc(1'h1, 8'h29, 16'he810, REF, "divider bad ratio");
        acc(1'h1, 8'h29, 16'hf004, REF, "divider other exponent");
        acc(1'h0, 8'h29, 16'h0000, {16'he808, 2'h0}, "divider kept");
        $display("test divider done");
    endtask

    // A zero offset keeps the expected target equal to the selected source word.
    task automatic test_target();
        logic [15:0] src [4] = '{16'h0133, 16'h0123, 16'h0142, 16'h0133};
        acc(1'h1, 8'h22, 16'h0000, 18'h0, "offset write");
        acc(1'h1, 8'h1b, 16'ha5a5, 18'h0, "mask write");
        chk("mask port", 112'(mask_q), 112'h0a5a5);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_sys);
            op_source_sel <= 2'(s);
            @(posedge clk_sys);
            #1;
            chk("target by source", 112'(tgt), 112'(src[s]));
        end
        acc(1'h1, 8'h22, 16'hfc00, 18'h0, "offset minus two");
        acc(1'h0, 8'h22, 16'h0000, {16'hfc00, 2'h0}, "offset read");
        @(posedge clk_sys);
        #1;
        chk("target clamped low", 112'(tgt), 112'h0);
        acc(1'h1, 8'h22, 16'h0001, 18'h0, "offset one step");
        acc(1'h1, 8'h24, 16'h0130, 18'h0, "ceiling write");
        @(posedge clk_sys);
        #1;
        chk("target at ceiling", 112'(tgt), 112'h0130);
        $display("test target done");
    endtask

    // Offset is one step and the ceiling 0130h here, so every sum stays below the clamp.
    task automatic test_word_regs();
        logic [7:0] cd [8] = '{8'h1b, 8'h21, 8'h25, 8'h26, 8'h27, 8'h33, 8'h35, 8'h36};
        logic [15:0] wv [8] = '{16'h5a5a, 16'h0100, 16'h0110, 16'h00f0, 16'he004, 16'h0320, 16'hf816,
                                16'hf814};
        logic [15:0] tv [3] = '{16'h0101, 16'h00f1, 16'h0111};
        for (int i = 0; i < 8; i++) begin
            acc(1'h1, cd[i], wv[i], 18'h0, "word write");
            acc(1'h0, cd[i], 16'h0000, {wv[i], 2'h0}, "word read");
        end
        chk("word ports", 112'({mask_q, ramp_q, sw_q, von_q, voff_q}),
            112'({wv[0], wv[4], wv[5], wv[6], wv[7]}));
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_sys);
            op_source_sel <= 2'(s);
            @(posedge clk_sys);
            #1;
            chk("target after writes", 112'(tgt), 112'(tv[s]));
        end
        $display("test word regs done");
    endtask

    // A second reset must reload the factory trim, now a negative one.
    task automatic test_reload();
        @(posedge clk_sys);
        op_source_sel <= 2'h0;
        trim_in <= 16'hffc0;
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        acc(1'h0, 8'h22, 16'h0000, {16'hffc0, 2'h0}, "trim after reset");
        acc(1'h0, 8'h21, 16'h0000, {16'h0133, 2'h0}, "setpoint after reset");
        chk("target after reset", 112'(tgt), 112'h00f3);
        $display("test reload done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        rst = 1'h1;
        op_source_sel = 2'h0;
        trim_in = TRIM;
        n_errors = 0;
        check_count = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        test_defaults();
        test_read_only();
        test_divider();
        test_target();
        test_word_regs();
        test_reload();
        stop_test();
    end

    // The tests need well under 200 cycles; the watchdog allows ten times that.
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule

`default_nettype wire

// ---- tb/pmv_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module pmv_host_model (
    // Clock
    input wire logic clk_sys,
    // Command port towards the bank
    output logic cmd_valid,
    output pmv_pkg::pmv_cmd_type cmd,
    input wire logic rsp_valid,
    input wire pmv_pkg::pmv_rsp_type rsp
);
    initial begin
        cmd_valid = 1'h0;
        cmd = '0;
    end

    // Between commands the fields carry the inverse of the last command,
    // so a stale value is never taken for a new one.
    task automatic xfer(input logic wr, input logic [7:0] cd, input logic [15:0] wd,
                        output logic got, output pmv_pkg::pmv_rsp_type r);
        @(posedge clk_sys);
        cmd_valid <= 1'h1;
        cmd <= {wr, cd, wd};
        @(posedge clk_sys);
        cmd_valid <= 1'h0;
        cmd <= ~{wr, cd, wd};
        #1;
        got = rsp_valid;
        r = rsp;
    endtask
endmodule

`default_nettype wire
